// ==== rtl/can_code_encoder_defines.svh ====
// Constants for the logical signal to CAN code encoder.
`ifndef CAN_CODE_ENCODER_DEFINES_SVH
`define CAN_CODE_ENCODER_DEFINES_SVH

`define HALF_VALUE        17'h08000
`define D1_FLAG_CODE      16'h0001
`define D2_ERR_CODE       16'h0002
`define D2_NA_CODE        16'h0003
`define D4_SPECIAL_OFFSET 16'h0002
`define D4_SPECIAL_MAX    16'h000D
`define D4_SPECIAL_MAXIDX 32'h0000000B
`define D4_ERR_CODE       16'h000E
`define D4_NA_CODE        16'h000F
`define B1_VALID_MAX      16'h00FA
`define B1_SPECIAL_BASE   16'h00FB
`define B1_SPECIAL_MAXIDX 32'h00000002
`define B1_SPECIAL_MAX    16'h00FD
`define B1_ERR_CODE       16'h00FE
`define B1_NA_CODE        16'h00FF
`define B2_VALID_MAX      16'hFAFF
`define B2_SPECIAL_BASE   16'hFB00
`define B2_SPECIAL_MAXIDX 32'h000002FF
`define B2_SPECIAL_MAX    16'hFDFF
`define B2_ERR_CODE       16'hFE00
`define B2_NA_CODE        16'hFF00
`define POS_MIN           4'h1
`define POS_MAX           4'h8
`define BITS_PER_BYTE     4'h8
`define NORM_FRAC_BITS    16

`endif

// ==== rtl/can_code_encoder_pkg.sv ====
// Types shared by the logical signal to CAN code encoder.
package can_code_encoder_pkg;

    typedef enum logic [2:0] {
        FIELD_UNDEFINED = 3'b000,
        FIELD_BIT1      = 3'b001,
        FIELD_BIT2      = 3'b010,
        FIELD_BIT4      = 3'b011,
        FIELD_BYTE1     = 3'b100,
        FIELD_BYTE2     = 3'b101,
        FIELD_BYTE4     = 3'b110
    } field_type_t;

    typedef enum logic [1:0] {
        SIG_VALID   = 2'b00,
        SIG_SPECIAL = 2'b01,
        SIG_ERROR   = 2'b10,
        SIG_NA      = 2'b11
    } sig_state_t;

    // Value is unsigned Q1.16: 17'h10000 stands for 1.0.
    typedef struct packed {
        sig_state_t  state;
        logic [16:0] value;
        logic [31:0] state_code_index;
    } logical_sig_t;

    // Continuous code = norm_base + value * norm_scale, clamped to the valid range.
    typedef struct packed {
        field_type_t ftype;
        logic [3:0]  pos_byte;
        logic [3:0]  pos_bit;
        logic [15:0] norm_scale;
        logic [15:0] norm_base;
    } field_cfg_t;

    typedef struct packed {
        logic [15:0] code;
        logic [63:0] data;
        logic [63:0] mask;
        logic        place_err;
    } enc_out_t;

endpackage : can_code_encoder_pkg

// ==== rtl/logical_to_can_code_encoder.sv ====
// Encodes one logical signal into its CAN signal code and places it in the frame.
`include "can_code_encoder_defines.svh"

module logical_to_can_code_encoder
    import can_code_encoder_pkg::*;
(
    input  wire logic         clk_sys,
    input  wire logic         resetn,
    input  wire logic         capture,
    input  wire logical_sig_t sig,
    input  wire field_cfg_t   cfg,
    output logic              out_valid,
    output enc_out_t          enc_out
);

    logic [15:0] code_next;
    logic [15:0] width_mask;
    logic [3:0]  width_bits;
    logic [3:0]  n_bytes;
    logic        discrete;
    logic        defined;
    logic        fits;
    logic [5:0]  shift;
    logic [32:0] product;
    logic [17:0] scaled;
    logic [63:0] data_next;
    logic [63:0] mask_next;
    logic        value_high;

    assign value_high = (sig.value >= `HALF_VALUE);
    assign product    = sig.value * {1'b0, cfg.norm_scale};
    assign scaled     = {1'b0, product[`NORM_FRAC_BITS +: 17]} + {2'b00, cfg.norm_base};

    // Code selection, purely combinational; the frame sees it only through the register loaded on capture.
    always_comb begin
        code_next = 16'h0000;
        case (cfg.ftype)
            FIELD_BIT1: begin
                if (sig.state == SIG_VALID) begin
                    code_next = value_high ? 16'h0001 : 16'h0000;
                end else begin
                    code_next = `D1_FLAG_CODE;
                end
            end
            FIELD_BIT2: begin
                case (sig.state)
                    SIG_VALID: code_next = value_high ? 16'h0001 : 16'h0000;
                    SIG_ERROR: code_next = `D2_ERR_CODE;
                    default:   code_next = `D2_NA_CODE;
                endcase
            end
            FIELD_BIT4: begin
                case (sig.state)
                    SIG_VALID: code_next = value_high ? 16'h0001 : 16'h0000;
                    SIG_SPECIAL: begin
                        // Indexes beyond the range saturate at the top special code.
                        if (sig.state_code_index > `D4_SPECIAL_MAXIDX) begin
                            code_next = `D4_SPECIAL_MAX;
                        end else begin
                            code_next = sig.state_code_index[15:0] + `D4_SPECIAL_OFFSET;
                        end
                    end
                    SIG_ERROR: code_next = `D4_ERR_CODE;
                    default:   code_next = `D4_NA_CODE;
                endcase
            end
            FIELD_BYTE1: begin
                case (sig.state)
                    SIG_VALID: begin
                        if (scaled > {2'b00, `B1_VALID_MAX}) begin
                            code_next = `B1_VALID_MAX;
                        end else begin
                            code_next = scaled[15:0];
                        end
                    end
                    SIG_SPECIAL: begin
                        if (sig.state_code_index > `B1_SPECIAL_MAXIDX) begin
                            code_next = `B1_SPECIAL_MAX;
                        end else begin
                            code_next = sig.state_code_index[15:0] + `B1_SPECIAL_BASE;
                        end
                    end
                    SIG_ERROR: code_next = `B1_ERR_CODE;
                    default:   code_next = `B1_NA_CODE;
                endcase
            end
            FIELD_BYTE2: begin
                case (sig.state)
                    SIG_VALID: begin
                        if (scaled > {2'b00, `B2_VALID_MAX}) begin
                            code_next = `B2_VALID_MAX;
                        end else begin
                            code_next = scaled[15:0];
                        end
                    end
                    SIG_SPECIAL: begin
                        if (sig.state_code_index > `B2_SPECIAL_MAXIDX) begin
                            code_next = `B2_SPECIAL_MAX;
                        end else begin
                            code_next = sig.state_code_index[15:0] + `B2_SPECIAL_BASE;
                        end
                    end
                    SIG_ERROR: code_next = `B2_ERR_CODE;
                    default:   code_next = `B2_NA_CODE;
                endcase
            end
            default: code_next = 16'h0000;
        endcase
    end

    // Field geometry per type; undefined and 4-byte fields place nothing.
    always_comb begin
        width_bits = 4'h0;
        n_bytes    = 4'h0;
        case (cfg.ftype)
            FIELD_BIT1:  width_bits = 4'h1;
            FIELD_BIT2:  width_bits = 4'h2;
            FIELD_BIT4:  width_bits = 4'h4;
            FIELD_BYTE1: n_bytes    = 4'h1;
            FIELD_BYTE2: n_bytes    = 4'h2;
            default:     width_bits = 4'h0;
        endcase
    end

    assign discrete = (width_bits != 4'h0);
    assign defined  = discrete || (n_bytes != 4'h0);

    // A discrete code must end inside its byte; a continuous one inside the frame.
    always_comb begin
        fits = 1'b0;
        if ((cfg.pos_byte >= `POS_MIN) && (cfg.pos_byte <= `POS_MAX)) begin
            if (discrete) begin
                fits = (cfg.pos_bit >= `POS_MIN) && (cfg.pos_bit <= `POS_MAX)
                       && ({1'b0, cfg.pos_bit} - 5'h01 + {1'b0, width_bits} <= {1'b0, `BITS_PER_BYTE});
            end else begin
                fits = ({1'b0, cfg.pos_byte} - 5'h01 + {1'b0, n_bytes} <= {1'b0, `POS_MAX});
            end
        end
    end

    always_comb begin
        shift = {cfg.pos_byte[2:0] - 3'h1, 3'h0};
        if (discrete) begin
            shift = {cfg.pos_byte[2:0] - 3'h1, cfg.pos_bit[2:0] - 3'h1};
        end
    end

    always_comb begin
        width_mask = 16'h0000;
        case (cfg.ftype)
            FIELD_BIT1:  width_mask = 16'h0001;
            FIELD_BIT2:  width_mask = 16'h0003;
            FIELD_BIT4:  width_mask = 16'h000F;
            FIELD_BYTE1: width_mask = 16'h00FF;
            FIELD_BYTE2: width_mask = 16'hFFFF;
            default:     width_mask = 16'h0000;
        endcase
    end

    // Continuous codes go least significant byte first, matching the frame layout.
    always_comb begin
        data_next = 64'h0000000000000000;
        mask_next = 64'h0000000000000000;
        if (defined && fits) begin
            data_next = {48'h000000000000, code_next & width_mask} << shift;
            mask_next = {48'h000000000000, width_mask} << shift;
        end
    end

    // Sample only on the frame assembly strobe so the frame sees a stable code.
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            enc_out <= '0;
        end else if (capture) begin
            enc_out.code      <= code_next;
            enc_out.data      <= data_next;
            enc_out.mask      <= mask_next;
            enc_out.place_err <= defined && !fits;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            out_valid <= 1'b0;
        end else begin
            out_valid <= capture;
        end
    end

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!resetn);

    sequence cap_discrete_valid;
        capture && discrete && (sig.state == SIG_VALID);
    endsequence

    sequence cap_type_state(field_type_t t, sig_state_t s);
        capture && (cfg.ftype == t) && (sig.state == s);
    endsequence

    AST_DISC_THRESHOLD: assert property (
        cap_discrete_valid |=> (enc_out.code == ($past(value_high) ? 16'h0001 : 16'h0000)))
        else $error("Discrete valid code does not follow the one-half threshold.");

    AST_BIT1_FLAGS: assert property (
        capture && (cfg.ftype == FIELD_BIT1) && (sig.state != SIG_VALID) |=> enc_out.code == 16'h0001)
        else $error("1-bit field non-valid state did not encode as 1.");

    AST_BIT2_CODES: assert property (
        cap_type_state(FIELD_BIT2, SIG_ERROR) |=> enc_out.code == 16'h0002)
        else $error("2-bit field error did not encode as 2.");

    AST_BIT2_NA: assert property (
        capture && (cfg.ftype == FIELD_BIT2) && (sig.state inside {SIG_SPECIAL, SIG_NA})
        |=> enc_out.code == 16'h0003)
        else $error("2-bit field special or not-available did not encode as 3.");

    AST_BIT4_SPECIAL: assert property (
        cap_type_state(FIELD_BIT4, SIG_SPECIAL) ##0 (sig.state_code_index < 32'h0000000C)
        |=> enc_out.code == $past(sig.state_code_index[15:0]) + 16'h0002)
        else $error("4-bit special code is not index plus two.");

    AST_BIT4_ERROR: assert property (
        cap_type_state(FIELD_BIT4, SIG_ERROR) |=> enc_out.code == 16'h000E)
        else $error("4-bit field error did not encode as 14.");

    AST_BYTE1_RANGE: assert property (
        cap_type_state(FIELD_BYTE1, SIG_VALID) |=> enc_out.code <= 16'h00FA)
        else $error("1-byte valid code above 250.");

    AST_BYTE1_ERROR: assert property (
        cap_type_state(FIELD_BYTE1, SIG_ERROR) |=> enc_out.code == 16'h00FE)
        else $error("1-byte field error did not encode as 254.");

    AST_BYTE2_RANGE: assert property (
        cap_type_state(FIELD_BYTE2, SIG_VALID) |=> enc_out.code <= 16'hFAFF)
        else $error("2-byte valid code above 64255.");

    AST_NO_STRADDLE: assert property (
        capture && discrete |=> ((enc_out.mask >> {$past(cfg.pos_byte[2:0]) - 3'h1, 3'h0})
                                 & 64'hFFFFFFFFFFFFFF00) == 64'h0000000000000000)
        else $error("Discrete field mask leaves its byte.");

    AST_HOLD_BETWEEN: assert property (
        !capture |=> $stable(enc_out) ##0 !out_valid)
        else $error("Output changed without a capture strobe.");

endmodule : logical_to_can_code_encoder

// ==== test/frame_rx_model.sv ====
// Receiving control unit stand-in that merges each handed-over field into its frame image.
module frame_rx_model
    import can_code_encoder_pkg::*;
(
    input  wire logic     clk_sys,
    input  wire logic     resetn,
    input  wire logic     out_valid,
    input  wire enc_out_t enc_out,
    output logic [63:0]   rx_data,
    output int unsigned   rx_count
);
    timeunit 1ns;
    timeprecision 1ps;
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            rx_data  <= 64'h0;
            rx_count <= 0;
        end else if (out_valid) begin
            rx_data  <= (rx_data & ~enc_out.mask) | (enc_out.data & enc_out.mask);
            rx_count <= rx_count + 1;
        end
    end
endmodule : frame_rx_model

// ==== test/tb_logical_to_can_code_encoder.sv ====
// Self-checking bench for the logical signal to CAN code encoder.
`define CHECK_EQ(got, exp) begin samples_checked++; if ((got) !== (exp)) begin err_count++; \
    $display("Error at %0t: got %0h expected %0h", $time, (got), (exp)); end end

module tb_logical_to_can_code_encoder
    import can_code_encoder_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic         clk_sys;
    logic         resetn;
    logic         capture;
    logical_sig_t sig;
    field_cfg_t   cfg;
    logic         out_valid;
    enc_out_t     enc_out;
    logic [63:0]  rx_data;
    int unsigned  rx_count;
    int           err_count;
    int           samples_checked;
    int           sent;
    enc_out_t     exp_q[$];
    logic [63:0]  frame_img;
    logic [16:0]  val_tab[8] = '{17'h00000, 17'h07FFF, 17'h08000, 17'h10000, 17'h00001, 17'h0FFFF, 17'h0C000, 17'h04000};
    logic [31:0]  idx_tab[8] = '{32'h0, 32'h2, 32'h3, 32'hB, 32'hC, 32'h2FF, 32'h300, 32'hFFFFFFFF};

    logical_to_can_code_encoder dut (.clk_sys(clk_sys), .resetn(resetn), .capture(capture), .sig(sig),
                                     .cfg(cfg), .out_valid(out_valid), .enc_out(enc_out));
    frame_rx_model rx (.clk_sys(clk_sys), .resetn(resetn), .out_valid(out_valid), .enc_out(enc_out),
                       .rx_data(rx_data), .rx_count(rx_count));

    always #2.5 clk_sys = ~clk_sys;

    // Expected code and placement, worked out independently of the design.
    function automatic enc_out_t predict(logical_sig_t s, field_cfg_t c);
        enc_out_t    e;
        logic [32:0] cv;
        logic [31:0] ix;
        int          w;
        int          pb;
        int          pt;
        int          sh;
        logic        fits;
        e  = '0;
        ix = s.state_code_index;
        pb = int'(c.pos_byte);
        pt = int'(c.pos_bit);
        cv = {17'h0, c.norm_base} + ((33'(s.value) * 33'(c.norm_scale)) >> 16);
        w  = (c.ftype == FIELD_BIT1) ? 1 : (c.ftype == FIELD_BIT2) ? 2 : (c.ftype == FIELD_BIT4) ? 4 : 8;
        case (c.ftype)
            FIELD_BIT1, FIELD_BIT2, FIELD_BIT4: begin
                case (s.state)
                    SIG_VALID:   e.code = (s.value >= 17'h08000) ? 16'h0001 : 16'h0000;
                    SIG_SPECIAL: e.code = (w == 1) ? 16'h0001 : (w == 2) ? 16'h0003 :
                                          (ix > 32'hB) ? 16'h000D : ix[15:0] + 16'h0002;
                    SIG_ERROR:   e.code = (w == 1) ? 16'h0001 : (w == 2) ? 16'h0002 : 16'h000E;
                    default:     e.code = (w == 1) ? 16'h0001 : (w == 2) ? 16'h0003 : 16'h000F;
                endcase
            end
            FIELD_BYTE1: begin
                case (s.state)
                    SIG_VALID:   e.code = (cv > 33'hFA) ? 16'h00FA : cv[15:0];
                    SIG_SPECIAL: e.code = (ix > 32'h2) ? 16'h00FD : ix[15:0] + 16'h00FB;
                    SIG_ERROR:   e.code = 16'h00FE;
                    default:     e.code = 16'h00FF;
                endcase
            end
            FIELD_BYTE2: begin
                w = 16;
                case (s.state)
                    SIG_VALID:   e.code = (cv > 33'hFAFF) ? 16'hFAFF : cv[15:0];
                    SIG_SPECIAL: e.code = (ix > 32'h2FF) ? 16'hFDFF : ix[15:0] + 16'hFB00;
                    SIG_ERROR:   e.code = 16'hFE00;
                    default:     e.code = 16'hFF00;
                endcase
            end
            default: return e;
        endcase
        fits = (pb >= 1) && (pb <= 8) && ((w < 8) ? (pt >= 1 && pt <= 8 && pt - 1 + w <= 8) : (pb - 1 + w / 8 <= 8));
        sh = (pb - 1) * 8 + ((w < 8) ? pt - 1 : 0);
        e.place_err = !fits;
        if (fits) begin
            e.mask = ((64'h1 << w) - 64'h1) << sh;
            e.data = 64'(e.code) << sh;
        end
        return e;
    endfunction : predict

    task automatic send(logical_sig_t s, field_cfg_t c);
        @(posedge clk_sys);
        #1;
        sig     = s;
        cfg     = c;
        capture = 1'b1;
        exp_q.push_back(predict(s, c));
        sent++;
    endtask : send

    task automatic idle(int n);
        repeat (n) begin
            @(posedge clk_sys);
            #1;
            capture = 1'b0;
        end
    endtask : idle

    task automatic test_done();
        if (err_count == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : test_done

    // Results are taken at the falling edge, clear of the edge that launched them.
    always @(negedge clk_sys) begin
        enc_out_t e;
        if (resetn && out_valid !== 1'b0) begin
            `CHECK_EQ(exp_q.size() != 0, 1'b1)
            if (exp_q.size() != 0) begin
                e = exp_q.pop_front();
                `CHECK_EQ(enc_out.code, e.code)
                `CHECK_EQ(enc_out.place_err, e.place_err)
                `CHECK_EQ(enc_out.mask, e.mask)
                `CHECK_EQ(enc_out.data, e.data)
                frame_img = (frame_img & ~e.mask) | (e.data & e.mask);
            end
        end
    end

    initial begin
        #15000;
        err_count++;
        test_done();
    end

    initial begin
        logical_sig_t s;
        field_cfg_t   c;
        enc_out_t     hold;
        int           seed;
        clk_sys = 1'b0;
        resetn = 1'b0;
        capture = 1'b0;
        sig = '0;
        cfg = '0;
        frame_img = 64'h0;
        seed = $urandom(22);
        repeat (8) @(posedge clk_sys);
        #1;
        resetn = 1'b1;
        @(negedge clk_sys);
        `CHECK_EQ({out_valid, enc_out}, '0)
        for (int t = 0; t < 7; t++) begin
            for (int st = 0; st < 4; st++) begin
                for (int k = 0; k < 14; k++) begin
                    s.state = sig_state_t'(st);
                    s.value = (k < 8) ? val_tab[k] : 17'($urandom_range(32'h10000, 0));
                    s.state_code_index = (k < 8) ? idx_tab[k] : $urandom();
                    c.ftype = field_type_t'(t);
                    c.pos_byte = 4'($urandom_range(9, 0));
                    c.pos_bit = (t >= 4) ? 4'($urandom_range(8, 1)) : 4'($urandom_range(9, 0));
                    // A small scale on odd steps keeps continuous codes below the clamp now and then.
                    c.norm_scale = k[0] ? 16'($urandom_range(255, 0)) : 16'($urandom());
                    c.norm_base = k[0] ? 16'($urandom_range(255, 0)) : 16'($urandom());
                    send(s, c);
                    if ($urandom_range(3, 0) == 0) begin
                        idle(1);
                    end
                end
            end
        end
        idle(1);
        @(negedge clk_sys);
        hold = enc_out;
        repeat (4) @(negedge clk_sys);
        `CHECK_EQ({out_valid, enc_out}, {1'b0, hold})
        idle(3);
        `CHECK_EQ(exp_q.size(), 0)
        `CHECK_EQ(rx_count, sent)
        `CHECK_EQ(rx_data, frame_img)
        test_done();
    end
endmodule : tb_logical_to_can_code_encoder
